/* dasw_top.sv */
/*
 * dasw_top: control logic of a two input failover selector feeding
 * twelve outputs, with panel indicator drive and AHB-Lite registers.
 * Assumes detector and fault inputs synchronous to hclk; raw buttons are synchronised here.
 */
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
// Operation
// - armed, primary fault of any kind reroutes outputs to a healthy secondary
// - after a switch, hold secondary and alarm until a clear arrives
// - auto press makes the currently selected input the primary
// - arming only when both inputs are validly detected
// - selected input drives all twelve outputs together
// - armed with everything healthy, nothing happens, alarm stays off
// - armed, primary good, secondary signal lost: disarm and raise alarm
// - armed, primary good, secondary external fault: disarm, alarm
// - armed, primary external fault with healthy secondary: switch, alarm
// - armed, primary signal lost with healthy secondary: switch, alarm
// - armed shows primary and auto indicators slowly flashing green
// - armed shows secondary indicator solid green
// - just after a switch, auto and failed input red, survivor selected
// - after ack, auto amber, selected flashing green, failed input red
// - failed input valid again: it shows amber, auto off, selection kept
// - restored input button selects it as primary, other solid green
// - later auto press with both valid re-arms, auto flashing green
// - per input termination select, low or high impedance, by command
// - per external fault input, command picks which level means fault
// - armed, external fault level raises alarm well within the latency bound
`timescale 1ns/1ns
`default_nettype none
module dasw_top
	import dasw_pkg::*;
#(
	parameter int DEB_COUNT = DEB_CYC,
	parameter int FLASH_COUNT = FLASH_CYC
)
(
	input wire logic hclk, // bus and system clock
	input wire logic hresetn, // async reset, active low
	input wire dasw_pkg::dasw_ahb_in_type ahb_in, // bus request
	output dasw_pkg::dasw_ahb_out_type ahb_out, // bus answer
	input wire logic [1:0] sig_det, // signal detected, bit0 A
	input wire logic [1:0] ext_flt, // external fault levels
	input wire logic [dasw_pkg::N_BTN-1:0] btn_raw, // raw buttons
	output logic [dasw_pkg::N_OUT-1:0] out_src_b, // 1: output fed by B
	output logic [1:0] term_hi, // 1: high impedance termination
	output logic alarm_out, // alarm relay drive
	output dasw_pkg::dasw_panel_type panel, // indicator states
	output logic flash_phase // slow flash lamp phase
);
	import dasw_pkg::*;
	// fault seen on input x, honouring enable and polarity
	function automatic logic flt_of(input logic [CTRL_W-1:0] c,
		input logic [1:0] lv, input int x);
		flt_of = c[CTRL_FEN_POS+x] & (lv[x] == c[CTRL_FPOL_POS+x]);
	endfunction
	localparam int DEB_W = $clog2(DEB_COUNT + 1);
	localparam int FL_W = $clog2(FLASH_COUNT + 1);
	logic [CTRL_W-1:0] ctrl_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic cmd_clr, cmd_auto, clr_evt, auto_evt;
	logic [N_BTN-1:0] btn_evt;
	dasw_state_type state_r;
	logic sel_r, failed_r, alarm_r;
	logic [1:0] flt, good;
	logic [FL_W-1:0] fl_cnt_r;
	logic fl_r, do_trip, do_disarm;
	logic [1:0] sel_btn;
	// fault decode is combinational, far below the latency bound
	assign flt[0] = flt_of(ctrl_r, ext_flt, 0);
	assign flt[1] = flt_of(ctrl_r, ext_flt, 1);
	assign good = sig_det & ~flt;
	// zero wait state slave, always OKAY
	assign ahb_out.hreadyout = 1'b1;
	assign ahb_out.hresp = 1'b0;
	assign ahb_out.hrdata = hrdata_r;
	// address phase capture of writes; hready is low only while
	// another slave stalls, and then no write of ours is pending
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else if (ahb_in.hready)
		begin
			wr_pend_r <= ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hwrite;
			wr_addr_r <= ahb_in.haddr[7:0];
		end
	end
	// control register, written in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_r <= CTRL_RST;
		else if (wr_pend_r && wr_addr_r == CTRL_OFS)
			ctrl_r <= ahb_in.hwdata[CTRL_W-1:0];
	end
	// command strobes last the data phase cycle only
	assign cmd_clr = wr_pend_r && wr_addr_r == CMD_OFS &&
		ahb_in.hwdata[CMD_CLR_POS];
	assign cmd_auto = wr_pend_r && wr_addr_r == CMD_OFS &&
		ahb_in.hwdata[CMD_AUTO_POS];
	// read data is fetched at the address phase edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_r <= 32'h00000000;
		else if (ahb_in.hready && ahb_in.hsel && ahb_in.htrans[1] &&
			!ahb_in.hwrite)
		begin
			case (ahb_in.haddr[7:0])
				CTRL_OFS:
					hrdata_r <= {26'h0000000, ctrl_r};
				STAT_OFS:
				begin
					hrdata_r <= 32'h00000000;
					hrdata_r[STAT_SEL_POS] <= sel_r;
					hrdata_r[STAT_ARM_POS] <= state_r == ST_ARMED;
					hrdata_r[STAT_ALM_POS] <= alarm_r;
					hrdata_r[STAT_DET_POS+:2] <= sig_det;
					hrdata_r[STAT_FLT_POS+:2] <= flt;
					hrdata_r[STAT_ST_POS+:3] <= state_r;
				end
				default:
					hrdata_r <= 32'h00000000;
			endcase
		end
	end
	// button conditioning, one lane per button
	genvar gi;
	generate
		for (gi = 0; gi < N_BTN; gi++)
		begin : g_btn
			logic s1_r, s2_r, stab_r, prev_r;
			logic [DEB_W-1:0] cnt_r;
			// two flop synchroniser; first flop feeds only the second
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end
				else
				begin
					s1_r <= btn_raw[gi];
					s2_r <= s1_r;
				end
			end
			// level must hold a full debounce time to be accepted
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					cnt_r <= '0;
					stab_r <= 1'b0;
				end
				else if (s2_r == stab_r)
					cnt_r <= '0;
				else if (cnt_r == DEB_W'(DEB_COUNT - 1))
				begin
					cnt_r <= '0;
					stab_r <= s2_r;
				end
				else
					cnt_r <= cnt_r + 1'b1;
			end
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
					prev_r <= 1'b0;
				else
					prev_r <= stab_r;
			end
			assign btn_evt[gi] = stab_r & ~prev_r;
		end
	endgenerate
	assign clr_evt = btn_evt[BTN_ALARM] | cmd_clr;
	assign auto_evt = btn_evt[BTN_AUTO] | cmd_auto;
	assign sel_btn = {btn_evt[BTN_B], btn_evt[BTN_A]};
	// armed evaluation of primary (selected) and secondary health
	always_comb
	begin
		do_trip = 1'b0;
		do_disarm = 1'b0;
		if (state_r == ST_ARMED)
		begin
			if (!good[sel_r])
			begin
				if (good[~sel_r])
					do_trip = 1'b1;
				else
					do_disarm = 1'b1;
			end
			else if (!good[~sel_r])
				do_disarm = 1'b1;
			// both healthy: stay armed, no action
		end
	end
	// selection state machine
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= ST_MANUAL;
			sel_r <= 1'b0;
			failed_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_MANUAL:
				begin
					// selected input stays the primary when arming
					if (auto_evt && good == 2'b11)
						state_r <= ST_ARMED;
					else if (sel_btn[0])
						sel_r <= 1'b0;
					else if (sel_btn[1])
						sel_r <= 1'b1;
				end
				ST_ARMED:
				begin
					if (do_trip)
					begin
						sel_r <= ~sel_r;
						failed_r <= sel_r;
						state_r <= ST_TRIPPED;
					end
					else if (do_disarm)
						state_r <= ST_DISARMED;
				end
				ST_TRIPPED:
				begin
					// latched on secondary until a clear arrives
					if (clr_evt)
						state_r <= ST_ACKED;
				end
				ST_ACKED:
					if (good[failed_r])
						state_r <= ST_RESTORED;
				ST_RESTORED:
				begin
					if (!good[failed_r])
						state_r <= ST_ACKED;
					else if (sel_btn[failed_r])
					begin
						sel_r <= failed_r;
						state_r <= ST_MANUAL;
					end
				end
				ST_DISARMED:
					if (clr_evt)
						state_r <= ST_MANUAL;
				default:
					state_r <= ST_MANUAL;
			endcase
		end
	end
	// alarm latch; a new cause beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			alarm_r <= 1'b0;
		else if (do_trip || do_disarm)
			alarm_r <= 1'b1;
		else if (clr_evt)
			alarm_r <= 1'b0;
	end
	// slow flash timebase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fl_cnt_r <= '0;
			fl_r <= 1'b0;
		end
		else if (fl_cnt_r == FL_W'(FLASH_COUNT - 1))
		begin
			fl_cnt_r <= '0;
			fl_r <= ~fl_r;
		end
		else
			fl_cnt_r <= fl_cnt_r + 1'b1;
	end
	// outputs follow the selection together, one register set
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_src_b <= '0;
			term_hi <= 2'b00;
			alarm_out <= 1'b0;
			flash_phase <= 1'b0;
		end
		else
		begin
			out_src_b <= {N_OUT{sel_r}};
			term_hi <= ctrl_r[CTRL_TERM_POS+:2];
			alarm_out <= alarm_r;
			flash_phase <= fl_r;
		end
	end

	// manual view of one input indicator
	function automatic dasw_led_type in_led(input logic g,
		input logic is_sel);
		if (!g)
			in_led = '{COL_RED, 1'b0};
		else
			in_led = '{COL_GREEN, is_sel};
	endfunction
	// indicator decode, registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			panel <= '0;
		else
		begin
			panel.in_a <= in_led(good[0], !sel_r);
			panel.in_b <= in_led(good[1], sel_r);
			panel.auto_led <= '{COL_OFF, 1'b0};
			panel.alarm <= alarm_r ? dasw_led_type'{COL_RED, 1'b1} :
				dasw_led_type'{COL_GREEN, 1'b0};
			case (state_r)
				ST_ARMED:
				begin
					// primary flashing, secondary solid
					panel.auto_led <= '{COL_GREEN, 1'b1};
					panel.in_a <= '{COL_GREEN, !sel_r};
					panel.in_b <= '{COL_GREEN, sel_r};
				end
				ST_TRIPPED, ST_ACKED:
				begin
					panel.auto_led <= (state_r == ST_TRIPPED) ?
						dasw_led_type'{COL_RED, 1'b0} :
						dasw_led_type'{COL_AMBER, 1'b0};
					if (failed_r)
					begin
						panel.in_b <= '{COL_RED, 1'b0};
						panel.in_a <= '{COL_GREEN, 1'b1};
					end
					else
					begin
						panel.in_a <= '{COL_RED, 1'b0};
						panel.in_b <= '{COL_GREEN, 1'b1};
					end
				end
				ST_RESTORED:
				begin
					// auto stays off until the restored input is accepted
					if (failed_r)
						panel.in_b <= '{COL_AMBER, 1'b0};
					else
						panel.in_a <= '{COL_AMBER, 1'b0};
				end
				ST_DISARMED:
					panel.auto_led <= '{COL_RED, 1'b0};
				default:
					panel.auto_led <= '{COL_OFF, 1'b0};
			endcase
		end
	end
endmodule
`default_nettype wire

/* dasw_pkg.sv */
/*
 * dasw_pkg: shared constants and types of the dual input autoswitch
 * control block.
 * Assumes one 10 MHz clock and an AHB-Lite register bus.
 */
`default_nettype none
package dasw_pkg;
	// clock rate
	localparam int CLK_HZ = 10000000;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	// control register fields and reset value
	localparam int CTRL_TERM_POS = 0;
	localparam int CTRL_FEN_POS = 2;
	localparam int CTRL_FPOL_POS = 4;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	// command register fields (write one to act)
	localparam int CMD_CLR_POS = 0;
	localparam int CMD_AUTO_POS = 1;
	// status register fields
	localparam int STAT_SEL_POS = 0;
	localparam int STAT_ARM_POS = 1;
	localparam int STAT_ALM_POS = 2;
	localparam int STAT_DET_POS = 3;
	localparam int STAT_FLT_POS = 5;
	localparam int STAT_ST_POS = 8;
	// button indices
	localparam int BTN_A = 0;
	localparam int BTN_B = 1;
	localparam int BTN_AUTO = 2;
	localparam int BTN_ALARM = 3;
	localparam int N_BTN = 4;
	// timing in milliseconds
	localparam int DEB_MS = 20;
	localparam int FLASH_MS = 500;
	localparam int FAULT_LAT_MS = 250;
	localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
	localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
	localparam int FAULT_LAT_CYC = CLK_HZ / 1000 * FAULT_LAT_MS;
	// number of distribution outputs
	localparam int N_OUT = 12;
	// indicator colours
	typedef enum logic [1:0] {
		COL_OFF,
		COL_GREEN,
		COL_RED,
		COL_AMBER
	} dasw_color_type;
	typedef struct packed {
		dasw_color_type color;
		logic flash;
	} dasw_led_type;
	typedef struct packed {
		dasw_led_type in_a;
		dasw_led_type in_b;
		dasw_led_type auto_led;
		dasw_led_type alarm;
	} dasw_panel_type;
	typedef enum logic [2:0] {
		ST_MANUAL,
		ST_ARMED,
		ST_TRIPPED,
		ST_ACKED,
		ST_RESTORED,
		ST_DISARMED
	} dasw_state_type;
	// AHB-Lite slave side signals
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
		logic [31:0] hwdata;
	} dasw_ahb_in_type;
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} dasw_ahb_out_type;
endpackage
`default_nettype wire

/* dasw_assertions.sv */
/* checker for the autoswitch control ports of dasw_top
 * bound to the top module from the testbench file */
`timescale 1ns/1ns
`default_nettype none
module dasw_assertions
	import dasw_pkg::*;
#(
	parameter int DEB_COUNT = 4,
	parameter int FLASH_COUNT = 8
)
(
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, active low
	input wire dasw_pkg::dasw_ahb_in_type ahb_in, // bus request
	input wire dasw_pkg::dasw_ahb_out_type ahb_out, // bus answer
	input wire logic [1:0] sig_det, // detectors
	input wire logic [1:0] ext_flt, // fault levels
	input wire logic [dasw_pkg::N_BTN-1:0] btn_raw, // buttons
	input wire logic [dasw_pkg::N_OUT-1:0] out_src_b, // output source
	input wire logic [1:0] term_hi, // terminations
	input wire logic alarm_out, // alarm relay
	input wire dasw_pkg::dasw_panel_type panel, // indicators
	input wire logic flash_phase // flash phase
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic sel;
	logic armed;
	logic fl_prev;
	logic fl_seen;
	int fl_cnt;
	assign sel = out_src_b[0];
	assign armed = panel.auto_led.color == COL_GREEN && panel.auto_led.flash;
	// flash period counter; the first period after reset is not judged
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fl_prev <= 1'b0;
			fl_seen <= 1'b0;
			fl_cnt <= 0;
		end
		else
		begin
			fl_prev <= flash_phase;
			fl_seen <= fl_seen | (flash_phase != fl_prev);
			fl_cnt <= (flash_phase != fl_prev) ? 0 : fl_cnt + 1;
		end
	end
	// switch lands two edges after the cause at the latest
	sequence switch_s;
		##[1:2] ($changed(out_src_b) && alarm_out);
	endsequence
	// armed with both detectors steady, so leds are settled
	sequence calm_arm_s;
		armed && sig_det == 2'h3 && $past(sig_det) == 2'h3;
	endsequence
	outs_same_a: assert property (out_src_b == {N_OUT{sel}})
		else $error("outputs disagree on source");
	bus_okay_a: assert property (ahb_out.hreadyout && !ahb_out.hresp)
		else $error("bus answer not ready or not okay");
	armed_leds_a: assert property (calm_arm_s |->
		(sel ? {panel.in_a, panel.in_b} : {panel.in_b, panel.in_a})
		== {COL_GREEN, 1'b0, COL_GREEN, 1'b1})
		else $error("armed input leds wrong");
	trip_leds_a: assert property ($rose(alarm_out) &&
		$changed(out_src_b) |->
		{panel.auto_led, sel ? panel.in_a : panel.in_b}
		== {COL_RED, 1'b0, COL_RED, 1'b0})
		else $error("tripped leds wrong");
	pri_loss_a: assert property (armed && !sig_det[sel] &&
		sig_det[!sel] |-> switch_s)
		else $error("no switch on primary loss");
	sec_loss_a: assert property (armed && sig_det[sel] && !sig_det[!sel]
		|-> ##[1:2] (alarm_out && !armed))
		else $error("no disarm on secondary loss");
	alarm_hold_a: assert property (alarm_out && $past(alarm_out)
		|-> $stable(out_src_b))
		else $error("selection moved while alarm held");
	flash_per_a: assert property (fl_seen && flash_phase != fl_prev
		|-> fl_cnt == FLASH_COUNT - 1)
		else $error("flash period wrong");
	flash_live_a: assert property (fl_seen |-> fl_cnt < FLASH_COUNT)
		else $error("flash phase stuck");
endmodule
`default_nettype wire

/* dasw_partner.sv */
/* model of detectors, external fault sources and panel buttons
 * tasks are called right after a rising edge of hclk */
`timescale 1ns/1ns
`default_nettype none
module dasw_partner
	import dasw_pkg::*;
#(
	parameter int DEB_COUNT = 4
)
(
	input wire logic hclk, // system clock
	output logic [1:0] sig_det, // detector levels
	output logic [1:0] ext_flt, // fault levels
	output logic [dasw_pkg::N_BTN-1:0] btn_raw // raw buttons
);
	// both signals present, no fault, nothing pressed
	initial
	begin
		sig_det = 2'h3;
		ext_flt = 2'h0;
		btn_raw = '0;
	end
	// hold n cycles, then release long enough to count as stable
	task automatic press(input int idx, input int n);
		btn_raw[idx] <= 1'b1;
		repeat (n) @(posedge hclk);
		btn_raw[idx] <= 1'b0;
		repeat (DEB_COUNT + 8) @(posedge hclk);
	endtask
	// detector and fault levels change together
	task automatic levels(input logic [1:0] d, input logic [1:0] f);
		sig_det <= d;
		ext_flt <= f;
	endtask
endmodule
`default_nettype wire

/* dasw_top_tb.sv */
/* self-checking bench for dasw_top over AHB-Lite and the panel
 * short debounce and flash counts keep the run brief */
`timescale 1ns/1ns
`default_nettype none
module dasw_top_tb;
	import dasw_pkg::*;
	localparam int DEB = 4;
	localparam int PR = DEB + 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	dasw_ahb_in_type breq = '0;
	dasw_ahb_in_type bin;
	dasw_ahb_out_type bout;
	logic [1:0] sig_det;
	logic [1:0] ext_flt;
	logic [N_BTN-1:0] btn_raw;
	logic [N_OUT-1:0] out_src_b;
	logic [1:0] term_hi;
	logic alarm_out;
	dasw_panel_type panel;
	logic [31:0] q;
	int error_cnt = 0;
	int n_checks = 0;
	wire logic [31:0] pv = {23'h0, panel.in_a, panel.in_b, panel.auto_led};
	always #50 hclk = ~hclk;
	// the single slave's hreadyout is the bus hready
	always_comb
	begin
		bin = breq;
		bin.hready = bout.hreadyout;
	end
	dasw_top #(.DEB_COUNT(DEB), .FLASH_COUNT(8)) uut (.hclk(hclk),
		.hresetn(hresetn), .ahb_in(bin), .ahb_out(bout), .sig_det(sig_det),
		.ext_flt(ext_flt), .btn_raw(btn_raw), .out_src_b(out_src_b),
		.term_hi(term_hi), .alarm_out(alarm_out), .panel(panel),
		.flash_phase());
	dasw_partner #(.DEB_COUNT(DEB)) pm (.hclk(hclk), .sig_det(sig_det),
		.ext_flt(ext_flt), .btn_raw(btn_raw));
	task automatic conclude;
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// next edge with hready high, bounded
	task automatic rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (bout.hreadyout !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				error_cnt++;
				conclude();
			end
			@(posedge hclk);
		end
	endtask
	// one single word transfer; read data lands in q
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		breq.hsel <= 1'b1;
		breq.haddr <= {24'h000000, a};
		breq.htrans <= 2'h2;
		breq.hwrite <= wr;
		breq.hsize <= 3'h2;
		rdy();
		breq.htrans <= 2'h0;
		breq.hwdata <= d;
		rdy();
		q = bout.hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	function automatic logic [31:0] p(input dasw_color_type a, b, u,
		input logic fa, fb, fu);
		return {23'h0, a, fa, b, fb, u, fu};
	endfunction
	function automatic logic [31:0] st(input logic [2:0] s,
		input logic [1:0] f, d, input logic al, ar, se);
		return {21'h0, s, 1'b0, f, d, al, ar, se};
	endfunction
	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// hang guard
	initial
	begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		conclude();
	end
	initial
	begin
		do_reset();
		rd(CTRL_OFS, 32'h0);
		rd(STAT_OFS, st(3'h0, 2'h0, 2'h3, 1'b0, 1'b0, 1'b0));
		rd(8'h0C, 32'h0);
		ahb(1'b1, CTRL_OFS, 32'hFFFFFFC3);
		rd(CTRL_OFS, 32'h3);
		chk(32'(term_hi), 32'h3);
		rd(CMD_OFS, 32'h0);
		ahb(1'b1, CTRL_OFS, 32'h0);
		// arming refused with input B missing
		pm.levels(2'h1, 2'h0);
		ahb(1'b1, CMD_OFS, 32'h2);
		rd(STAT_OFS, st(3'h0, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0));
		pm.levels(2'h3, 2'h0);
		pm.press(BTN_B, 2);
		chk(32'(out_src_b), 32'h0);
		pm.press(BTN_B, PR);
		chk(32'(out_src_b), 32'hFFF);
		pm.press(BTN_AUTO, PR);
		chk(pv, p(COL_GREEN, COL_GREEN, COL_GREEN,
			1'b0, 1'b1, 1'b1));
		repeat (20) @(posedge hclk);
		rd(STAT_OFS, st(3'h1, 2'h0, 2'h3, 1'b0, 1'b1, 1'b1));
		// primary B loses its signal
		pm.levels(2'h1, 2'h0);
		repeat (3) @(posedge hclk);
		chk(32'(out_src_b), 32'h0);
		chk(pv & 32'h3F, p(COL_OFF, COL_RED, COL_RED,
			1'b0, 1'b0, 1'b0));
		chk(32'(panel.alarm), {29'h0, COL_RED, 1'b1});
		repeat (20) @(posedge hclk);
		rd(STAT_OFS, st(3'h2, 2'h0, 2'h1, 1'b1, 1'b0, 1'b0));
		pm.press(BTN_ALARM, PR);
		chk(pv, p(COL_GREEN, COL_RED, COL_AMBER, 1'b1, 1'b0, 1'b0));
		chk(32'(alarm_out), 32'h0);
		chk(32'(panel.alarm), {29'h0, COL_GREEN, 1'b0});
		pm.levels(2'h3, 2'h0);
		repeat (3) @(posedge hclk);
		chk(pv & 32'h3F, p(COL_OFF, COL_AMBER, COL_OFF,
			1'b0, 1'b0, 1'b0));
		chk(32'(out_src_b), 32'h0);
		pm.press(BTN_B, PR);
		chk(pv, p(COL_GREEN, COL_GREEN, COL_OFF, 1'b0, 1'b1, 1'b0));
		chk(32'(out_src_b), 32'hFFF);
		pm.press(BTN_AUTO, PR);
		chk(pv, p(COL_GREEN, COL_GREEN, COL_GREEN, 1'b0, 1'b1, 1'b1));
		// secondary A lost while armed on B
		pm.levels(2'h2, 2'h0);
		repeat (3) @(posedge hclk);
		rd(STAT_OFS, st(3'h5, 2'h0, 2'h2, 1'b1, 1'b0, 1'b1));
		ahb(1'b1, CMD_OFS, 32'h1);
		rd(STAT_OFS, st(3'h0, 2'h0, 2'h2, 1'b0, 1'b0, 1'b1));
		// high level faults input A, armed on A
		pm.levels(2'h3, 2'h0);
		pm.press(BTN_A, PR);
		chk(32'(out_src_b), 32'h0);
		do_reset();
		ahb(1'b1, CTRL_OFS, 32'h14);
		ahb(1'b1, CMD_OFS, 32'h2);
		rd(STAT_OFS, st(3'h1, 2'h0, 2'h3, 1'b0, 1'b1, 1'b0));
		pm.levels(2'h3, 2'h1);
		repeat (3) @(posedge hclk);
		chk(32'(out_src_b), 32'hFFF);
		rd(STAT_OFS, st(3'h2, 2'h1, 2'h3, 1'b1, 1'b0, 1'b1));
		// low level faults input B, the secondary
		pm.levels(2'h3, 2'h2);
		do_reset();
		ahb(1'b1, CTRL_OFS, 32'h08);
		ahb(1'b1, CMD_OFS, 32'h2);
		pm.levels(2'h3, 2'h0);
		repeat (3) @(posedge hclk);
		rd(STAT_OFS, st(3'h5, 2'h2, 2'h3, 1'b1, 1'b0, 1'b0));
		conclude();
	end
endmodule
bind dasw_top dasw_assertions #(.DEB_COUNT(DEB_COUNT),
	.FLASH_COUNT(FLASH_COUNT)) chk_i (.hclk(hclk), .hresetn(hresetn),
	.ahb_in(ahb_in), .ahb_out(ahb_out), .sig_det(sig_det),
	.ext_flt(ext_flt), .btn_raw(btn_raw), .out_src_b(out_src_b),
	.term_hi(term_hi), .alarm_out(alarm_out), .panel(panel),
	.flash_phase(flash_phase));
`default_nettype wire
